// [verilog/jps_map.vh]
// Constants for the scan pin sharing control block.
`ifndef JPS_MAP_VH
`define JPS_MAP_VH
`define JPS_ST_RESET     4'h0
`define JPS_ST_IDLE      4'h1
`define JPS_ST_SEL_DR    4'h2
`define JPS_ST_CAP_DR    4'h3
`define JPS_ST_SHIFT_DR  4'h4
`define JPS_ST_EXIT1_DR  4'h5
`define JPS_ST_PAUSE_DR  4'h6
`define JPS_ST_EXIT2_DR  4'h7
`define JPS_ST_UPD_DR    4'h8
`define JPS_ST_SEL_IR    4'h9
`define JPS_ST_CAP_IR    4'ha
`define JPS_ST_SHIFT_IR  4'hb
`define JPS_ST_EXIT1_IR  4'hc
`define JPS_ST_PAUSE_IR  4'hd
`define JPS_ST_EXIT2_IR  4'he
`define JPS_ST_UPD_IR    4'hf
`define JPS_IR_WIDTH     4
`define JPS_IR_BYPASS    4'hf
`define JPS_IR_CHECKSUM  4'h5
`define JPS_IR_RESET_VAL 4'hf
`define JPS_CSUM_CYCLES  8'h20
`endif

// [verilog/jps_tap_fsm.v]
// Scan state machine stepped by one test-clock rising edge pulse.
`timescale 1ns/1ps
`include "jps_map.vh"
module jps_tap_fsm
(
  input  wire       clk_in,
  input  wire       rst_b_in,
  input  wire       init_in,
  input  wire       step_in,
  input  wire       mode_sel_in,
  output reg  [3:0] state_out
);
  reg [3:0] next_state;

  always @*
  begin
    case (state_out)
      `JPS_ST_RESET:    next_state = mode_sel_in ? `JPS_ST_RESET : `JPS_ST_IDLE;
      `JPS_ST_IDLE:     next_state = mode_sel_in ? `JPS_ST_SEL_DR : `JPS_ST_IDLE;
      `JPS_ST_SEL_DR:   next_state = mode_sel_in ? `JPS_ST_SEL_IR : `JPS_ST_CAP_DR;
      `JPS_ST_CAP_DR:   next_state = mode_sel_in ? `JPS_ST_EXIT1_DR : `JPS_ST_SHIFT_DR;
      `JPS_ST_SHIFT_DR: next_state = mode_sel_in ? `JPS_ST_EXIT1_DR : `JPS_ST_SHIFT_DR;
      `JPS_ST_EXIT1_DR: next_state = mode_sel_in ? `JPS_ST_UPD_DR : `JPS_ST_PAUSE_DR;
      `JPS_ST_PAUSE_DR: next_state = mode_sel_in ? `JPS_ST_EXIT2_DR : `JPS_ST_PAUSE_DR;
      `JPS_ST_EXIT2_DR: next_state = mode_sel_in ? `JPS_ST_UPD_DR : `JPS_ST_SHIFT_DR;
      `JPS_ST_UPD_DR:   next_state = mode_sel_in ? `JPS_ST_SEL_DR : `JPS_ST_IDLE;
      `JPS_ST_SEL_IR:   next_state = mode_sel_in ? `JPS_ST_RESET : `JPS_ST_CAP_IR;
      `JPS_ST_CAP_IR:   next_state = mode_sel_in ? `JPS_ST_EXIT1_IR : `JPS_ST_SHIFT_IR;
      `JPS_ST_SHIFT_IR: next_state = mode_sel_in ? `JPS_ST_EXIT1_IR : `JPS_ST_SHIFT_IR;
      `JPS_ST_EXIT1_IR: next_state = mode_sel_in ? `JPS_ST_UPD_IR : `JPS_ST_PAUSE_IR;
      `JPS_ST_PAUSE_IR: next_state = mode_sel_in ? `JPS_ST_EXIT2_IR : `JPS_ST_PAUSE_IR;
      `JPS_ST_EXIT2_IR: next_state = mode_sel_in ? `JPS_ST_UPD_IR : `JPS_ST_SHIFT_IR;
      `JPS_ST_UPD_IR:   next_state = mode_sel_in ? `JPS_ST_SEL_DR : `JPS_ST_IDLE;
      default:          next_state = `JPS_ST_RESET;
    endcase
  end

  // Five high samples reach the reset state from any state.
  always @(posedge clk_in)
  begin
    if (!rst_b_in || init_in)
      state_out <= `JPS_ST_RESET;
    else if (step_in)
      state_out <= next_state;
  end
endmodule

// [verilog/jps_pin_share.v]
// Sharing of the scan pins with user I/O, with the scan controller.
// Functional notes
// RULE_01: Flexible mode: mode select low claims pins.
// RULE_02: Pins stay claimed until logic-reset state.
// RULE_03: Five high-select clocks reach logic-reset.
// RULE_04: Dedicated mode: standard scan port, unshared.
// RULE_05: Scan reset low initialises scan logic.
// RULE_06: Undriven scan reset reads high.
// RULE_07: Unreserved reset pin is plain user I/O.
// RULE_08: Checksum drives data out, then releases.
// RULE_09: Serial data in, results shifted out.
// RULE_10: Mode and reservation are static straps.
`timescale 1ns/1ps
`include "jps_map.vh"
module jps_pin_share
#(
  parameter IR_W     = `JPS_IR_WIDTH,
  parameter CSUM_LEN = `JPS_CSUM_CYCLES
)
(
  input  wire        clk_in,
  input  wire        rst_b_in,
  input  wire        dedicated_mode_in,
  input  wire        reserve_rst_in,
  input  wire        mode_sel_in,
  input  wire        tck_pin_in,
  input  wire        tdi_pin_in,
  input  wire        trst_b_pin_in,
  input  wire        trst_pin_drive_in,
  input  wire        tdo_user_in,
  input  wire        tdo_user_oe_in,
  input  wire        bsr_data_in,
  input  wire [7:0]  csum_data_in,
  output reg         scan_active_out,
  output wire        tck_user_out,
  output wire        tdi_user_out,
  output wire        trst_user_out,
  output reg         tdo_out,
  output reg         tdo_oe_out,
  output reg         csum_busy_out,
  output wire [3:0]  tap_state_out,
  output reg  [IR_W-1:0] instr_out
);
  reg  [1:0] tck_sync;
  reg  [1:0] tms_sync;
  reg  [1:0] tdi_sync;
  reg  [1:0] trst_sync;
  reg        tck_last;
  reg        dedicated;
  reg        reserve_rst;
  reg        strap_taken;
  reg  [IR_W-1:0] ir_shift;
  reg        bypass_bit;
  reg  [7:0] csum_shift;
  reg  [7:0] csum_count;
  wire [3:0] st;
  wire       tck_rise;
  wire       tck_fall;
  wire       scan_rst;
  wire       trst_pin_level;

  // Straps are captured once after reset release and then held.
  always @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      dedicated   <= 1'b0;
      reserve_rst <= 1'b0;
      strap_taken <= 1'b0;
    end
    else if (!strap_taken)
    begin
      dedicated   <= dedicated_mode_in; // RULE_10
      reserve_rst <= reserve_rst_in;    // RULE_10
      strap_taken <= 1'b1;
    end
  end

  // An undriven reset pin reads high, as if pulled up.
  assign trst_pin_level = trst_pin_drive_in ? trst_b_pin_in : 1'b1; // RULE_06

  // Two-stage synchronisers; the first stage feeds only the second.
  always @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      tck_sync  <= 2'h0;
      tms_sync  <= 2'h3;
      tdi_sync  <= 2'h0;
      trst_sync <= 2'h3;
      tck_last  <= 1'b0;
    end
    else
    begin
      tck_sync  <= {tck_sync[0], tck_pin_in};
      tms_sync  <= {tms_sync[0], mode_sel_in};
      tdi_sync  <= {tdi_sync[0], tdi_pin_in};
      trst_sync <= {trst_sync[0], trst_pin_level};
      tck_last  <= tck_sync[1];
    end
  end

  assign tck_rise = tck_sync[1] & ~tck_last;
  assign tck_fall = ~tck_sync[1] & tck_last;
  // The reset acts at once without test-clock edges; in this sampled
  // model that is the third system clock, after the two-stage synchroniser.
  assign scan_rst = reserve_rst & ~trst_sync[1]; // RULE_05 RULE_07

  jps_tap_fsm u_fsm
  (
    .clk_in      (clk_in),
    .rst_b_in    (rst_b_in),
    .init_in     (scan_rst),
    .step_in     (tck_rise), // RULE_03
    .mode_sel_in (tms_sync[1]),
    .state_out   (st)
  );
  assign tap_state_out = st;

  // Pin ownership.
  always @(posedge clk_in)
  begin
    if (!rst_b_in)
      scan_active_out <= 1'b0;
    else if (dedicated)
      scan_active_out <= 1'b1; // RULE_04
    else if (scan_rst)
      scan_active_out <= 1'b0;
    else if (!tms_sync[1])
      scan_active_out <= 1'b1; // RULE_01
    else if (st == `JPS_ST_RESET)
      scan_active_out <= 1'b0; // RULE_02
  end

  assign tck_user_out  = scan_active_out ? 1'b0 : tck_sync[1];
  assign tdi_user_out  = scan_active_out ? 1'b0 : tdi_sync[1];
  assign trst_user_out = reserve_rst ? 1'b1 : trst_sync[1]; // RULE_07

  // Instruction and data shifting.
  always @(posedge clk_in)
  begin
    if (!rst_b_in || scan_rst || st == `JPS_ST_RESET)
    begin
      ir_shift   <= {IR_W{1'b0}};
      instr_out  <= `JPS_IR_RESET_VAL;
      bypass_bit <= 1'b0;
      csum_shift <= 8'h00;
    end
    else if (tck_rise && scan_active_out)
    begin
      case (st)
        `JPS_ST_CAP_IR:   ir_shift <= {{(IR_W-1){1'b0}}, 1'b1};
        `JPS_ST_SHIFT_IR: ir_shift <= {tdi_sync[1], ir_shift[IR_W-1:1]}; // RULE_09
        `JPS_ST_UPD_IR:   instr_out <= ir_shift;
        `JPS_ST_CAP_DR:   csum_shift <= csum_data_in;
        `JPS_ST_SHIFT_DR:
        begin
          bypass_bit <= tdi_sync[1]; // RULE_09
          csum_shift <= {tdi_sync[1], csum_shift[7:1]};
        end
        default:          bypass_bit <= bypass_bit;
      endcase
    end
  end

  // Checksum run: drives the data pin for a fixed count of test clocks.
  always @(posedge clk_in)
  begin
    if (!rst_b_in || scan_rst)
    begin
      csum_busy_out <= 1'b0;
      csum_count    <= 8'h00;
    end
    else if (tck_rise && st == `JPS_ST_UPD_IR && ir_shift == `JPS_IR_CHECKSUM)
    begin
      csum_busy_out <= 1'b1; // RULE_08
      csum_count    <= CSUM_LEN[7:0];
    end
    else if (csum_busy_out && tck_rise)
    begin
      if (csum_count == 8'h01)
        csum_busy_out <= 1'b0; // RULE_08
      csum_count <= csum_count - 8'h01;
    end
  end

  // Data out changes on the falling test-clock edge, as the tester
  // samples on the rising one.
  always @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      tdo_out    <= 1'b0;
      tdo_oe_out <= 1'b0;
    end
    else if (csum_busy_out || (scan_active_out &&
             (st == `JPS_ST_SHIFT_IR || st == `JPS_ST_SHIFT_DR)))
    begin
      tdo_oe_out <= 1'b1; // RULE_08
      if (tck_fall)
      begin
        if (st == `JPS_ST_SHIFT_IR)
          tdo_out <= ir_shift[0]; // RULE_09
        else if (instr_out == `JPS_IR_CHECKSUM)
          tdo_out <= csum_shift[0];
        else if (instr_out == `JPS_IR_BYPASS)
          tdo_out <= bypass_bit;
        else
          tdo_out <= bsr_data_in;
      end
    end
    else if (scan_active_out)
    begin
      tdo_oe_out <= 1'b0;
    end
    else
    begin
      tdo_out    <= tdo_user_in;
      tdo_oe_out <= tdo_user_oe_in;
    end
  end
endmodule

// [dv/jps_tester.sv]
// Tester model driving the scan clock, select and data pins.
`timescale 1ns/1ps
module jps_tester
(
  input  wire clk_in,
  output reg  tck_out,
  output reg  tms_out,
  output reg  tdi_out
);
  initial
  begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
  end
  // One 160 ns clock per call; it rests low between calls, never free-running.
  task tck_bit(input m, input d);
    begin
      @(posedge clk_in);
      tms_out <= m;
      tdi_out <= d;
      repeat (7) @(posedge clk_in);
      tck_out <= 1'b1;
      repeat (8) @(posedge clk_in);
      tck_out <= 1'b0;
    end
  endtask
endmodule

// [dv/jps_pin_share_props.sv]
// Concurrent checks on the scan pin sharing block.
`timescale 1ns/1ps
`include "jps_map.vh"
module jps_pin_share_props
#(
  parameter IR_W = 4
)
(
  input wire            clk_in,
  input wire            rst_b_in,
  input wire            dedicated_mode_in,
  input wire            reserve_rst_in,
  input wire            mode_sel_in,
  input wire            tck_pin_in,
  input wire            trst_b_pin_in,
  input wire            trst_pin_drive_in,
  input wire            scan_active_out,
  input wire            tck_user_out,
  input wire            trst_user_out,
  input wire            tdo_oe_out,
  input wire            csum_busy_out,
  input wire [3:0]      tap_state_out,
  input wire [IR_W-1:0] instr_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  wire pin_rst = reserve_rst_in && trst_pin_drive_in;
  sequence s_sel_low;
    (!dedicated_mode_in && !mode_sel_in) [*6];
  endsequence
  sequence s_pin_low;
    (pin_rst && !trst_b_pin_in) [*6];
  endsequence
  a_user_clk_gated: assert property (scan_active_out |-> !tck_user_out)
    else $error("user clock seen while scanning");
  a_claim_on_select: assert property (s_sel_low |-> scan_active_out)
    else $error("pins not claimed");
  a_user_clk_follows: assert property (!scan_active_out |->
    tck_user_out == $past(tck_pin_in, 2)) else $error("user clock not passed through");
  a_release_at_reset: assert property ($fell(scan_active_out) |->
    tap_state_out == `JPS_ST_RESET) else $error("early release");
  a_hold_until_reset: assert property (scan_active_out && !pin_rst &&
    tap_state_out != `JPS_ST_RESET |=> scan_active_out) else $error("claim lost");
  a_dedicated_claim: assert property (dedicated_mode_in [*5] |-> scan_active_out)
    else $error("dedicated pins released");
  a_scan_reset_init: assert property (s_pin_low |-> tap_state_out == `JPS_ST_RESET
    && instr_out == `JPS_IR_RESET_VAL) else $error("scan reset ignored");
  a_float_reads_high: assert property ((!trst_pin_drive_in) [*4] |-> trst_user_out)
    else $error("floating reset pin low");
  a_csum_drives_out: assert property (csum_busy_out |-> instr_out == `JPS_IR_CHECKSUM
    ##1 tdo_oe_out) else $error("checksum output off");
endmodule
bind jps_pin_share jps_pin_share_props #(.IR_W(IR_W)) u_props
(
  .clk_in(clk_in), .rst_b_in(rst_b_in), .dedicated_mode_in(dedicated_mode_in),
  .tck_pin_in(tck_pin_in),
  .reserve_rst_in(reserve_rst_in), .mode_sel_in(mode_sel_in), .trst_b_pin_in(trst_b_pin_in),
  .trst_pin_drive_in(trst_pin_drive_in), .scan_active_out(scan_active_out),
  .tck_user_out(tck_user_out), .trst_user_out(trst_user_out), .tdo_oe_out(tdo_oe_out),
  .csum_busy_out(csum_busy_out), .tap_state_out(tap_state_out), .instr_out(instr_out)
);

// [dv/testbench.sv]
// Self-checking bench for the scan pin sharing block.
`timescale 1ns/1ps
`include "jps_map.vh"
module testbench;
  reg        clk_in = 1'b0;
  reg        rst_b_in = 1'b0;
  reg        dedicated_mode_in = 1'b0;
  reg        reserve_rst_in = 1'b0;
  reg        trst_b_pin_in = 1'b1;
  reg        trst_pin_drive_in = 1'b0;
  wire       tck, tms, tdi, scan_active_out, tck_user_out, trst_user_out;
  wire       tdo_out, tdo_oe_out, csum_busy_out, tdi_user_out;
  wire [3:0] tap_state_out, instr_out;
  integer    n_mismatch = 0;
  integer    num_checks = 0;
  integer    b;
  always #5 clk_in = ~clk_in;
  jps_tester tst (.clk_in(clk_in), .tck_out(tck), .tms_out(tms), .tdi_out(tdi));
  jps_pin_share DUT
  (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .dedicated_mode_in(dedicated_mode_in),
    .reserve_rst_in(reserve_rst_in), .mode_sel_in(tms), .tck_pin_in(tck), .tdi_pin_in(tdi),
    .trst_b_pin_in(trst_b_pin_in), .trst_pin_drive_in(trst_pin_drive_in), .tdo_user_in(1'b0),
    .tdo_user_oe_in(1'b1), .bsr_data_in(1'b1), .csum_data_in(8'ha5),
    .scan_active_out(scan_active_out), .tck_user_out(tck_user_out), .tdi_user_out(tdi_user_out),
    .trst_user_out(trst_user_out), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out),
    .csum_busy_out(csum_busy_out), .tap_state_out(tap_state_out), .instr_out(instr_out)
  );
  task check(input [7:0] seen, input [7:0] want);
    begin
      num_checks = num_checks + 1;
      if (seen !== want)
      begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // Straps are only taken at reset release, so each mode needs its own reset.
  task restart(input d, input r);
    begin
      @(posedge clk_in);
      rst_b_in <= 1'b0;
      dedicated_mode_in <= d;
      reserve_rst_in <= r;
      repeat (8) @(posedge clk_in);
      rst_b_in <= 1'b1;
      repeat (4) @(posedge clk_in);
    end
  endtask
  task seq(input [39:0] m, input [39:0] d, input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1)
        tst.tck_bit(m[i], d[i]);
      repeat (8) @(posedge clk_in);
    end
  endtask
  initial
  begin
    repeat (50000) @(posedge clk_in);
    n_mismatch = n_mismatch + 1;
    tally_and_finish;
  end
  initial
  begin
    restart(1'b0, 1'b0);
    check(instr_out, `JPS_IR_RESET_VAL);
    check(scan_active_out, 1'b0);
    check(trst_user_out, 1'b1);
    trst_pin_drive_in <= 1'b1;
    trst_b_pin_in <= 1'b0;
    seq(40'h0, 40'h0, 1);
    check(tap_state_out, `JPS_ST_IDLE);
    check(trst_user_out, 1'b0);
    check(scan_active_out, 1'b1);
    trst_b_pin_in <= 1'b1;
    trst_pin_drive_in <= 1'b0;
    seq(40'h1, 40'h0, 3);
    for (b = 1; b >= 0; b = b - 1)
    begin
      seq(40'h0, b, 1);
      check(tdo_out, b);
      check(tdo_oe_out, 1'b1);
      check(tdi_user_out, 1'b0);
    end
    seq(40'hf, 40'h0, 4);
    check(scan_active_out, 1'b1);
    seq(40'h1, 40'h0, 1);
    check(tap_state_out, `JPS_ST_RESET);
    check(scan_active_out, 1'b0);
    seq(40'h306, 40'h0a0, 11);
    check(instr_out, `JPS_IR_CHECKSUM);
    check(csum_busy_out, 1'b1);
    seq(40'h0, 40'h0, 30);
    check(csum_busy_out, 1'b1);
    seq(40'h0, 40'h0, 2);
    check(csum_busy_out, 1'b0);
    check(tdo_oe_out, 1'b0);
    // Load an all-zero instruction so the boundary bit reaches the data pin.
    seq(40'h583, 40'h0, 13);
    check(instr_out, 4'h0);
    check(tdo_out, 1'b1);
    seq(40'h1f, 40'h10, 5);
    check(tdo_oe_out, 1'b1);
    check(tdo_out, 1'b0);
    check(tdi_user_out, 1'b1);
    restart(1'b0, 1'b1);
    trst_b_pin_in <= 1'b0;
    seq(40'h2, 40'h0, 2);
    check(tap_state_out, `JPS_ST_SEL_DR);
    trst_pin_drive_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    check(tap_state_out, `JPS_ST_RESET);
    check(trst_user_out, 1'b1);
    trst_pin_drive_in <= 1'b0;
    trst_b_pin_in <= 1'b1;
    restart(1'b1, 1'b0);
    dedicated_mode_in <= 1'b0;
    seq(40'h1f, 40'h0, 5);
    check(scan_active_out, 1'b1);
    tally_and_finish;
  end
endmodule
